/* File: core/upis_defs.vh */
/*
 * constants for the usb power and interrupt status block:
 * register byte addresses, field positions, reset values, timing.
 * assumes a 40 mhz system clock and a 32-bit axi4-lite register bus.
 */
`ifndef UPIS_DEFS_VH
`define UPIS_DEFS_VH

// register byte addresses
`define UPIS_ADDR_PM      32'hf00e0004
`define UPIS_ADDR_INTR    32'hf00e0008
`define UPIS_ADDR_IRQCTL  32'hf00e002c

// reset values
`define UPIS_PM_RST       8'h00
`define UPIS_INTR_RST     12'h000

// power management control fields
`define UPIS_PM_SUSALLOW  0
`define UPIS_PM_SUSSTATE  1
`define UPIS_PM_RESDRIVE  2
`define UPIS_PM_BUSRST    3
`define UPIS_PM_TXSWAP    4
`define UPIS_PM_RXSWAP    5
`define UPIS_PM_FSYNC     7
`define UPIS_PM_RSVD      6

// interrupt status fields
`define UPIS_IS_EP0       0
`define UPIS_IS_EPLO      1
`define UPIS_IS_EPHI      4
`define UPIS_IS_SUS       8
`define UPIS_IS_RES       9
`define UPIS_IS_RST       10
`define UPIS_IS_DISC      11
`define UPIS_IS_RSVLO     5
`define UPIS_IS_RSVHI     7

// clear masks: read clears bits 0..10, write-one clears bit 11
`define UPIS_IS_RDCLR     12'h7ff
`define UPIS_IS_W1C       12'h800

// irq control field
`define UPIS_IC_SUSEN     0

// axi responses
`define UPIS_RESP_OKAY    2'h0
`define UPIS_RESP_SLVERR  2'h2

// timing: clock rate and idle / reset intervals in microseconds
`define UPIS_CLK_HZ       40000000
`define UPIS_IDLE_US      3000
`define UPIS_SE0_US       3000

`endif

/* File: core/upis_core.v */
/*
 * usb power management and interrupt status logic with an
 * axi4-lite register slave, data swap paths and iso frame sync.
 * assumes all inputs synchronous to mclk and serial-engine event
 * inputs presented as one-cycle pulses.
 */
// The AXI4-Lite register port is this design's own decision.
// Behaviour
// - suspend entry only when suspend allow set
// - suspend state flag sets on suspend entry
// - suspend flag clears on resume-drive clear, resume read
// - drive resume while suspended and resume-drive set
// - bus-reset bit follows persisting reset, read only
// - transmit swap bit swaps core-to-engine data
// - receive swap bit swaps engine-to-core data
// - frame sync iso waits for sof after ready
// - endpoint bits: ep0 bit0, ep1..4 bits 1..4
// - ep0 bit sets on its five events
// - bulk endpoint bit sets on its events
// - iso endpoint bit adds underrun event
// - suspend bit sets every 3ms idle
// - suspend interrupt disabled after reset
// - resume bit sets on resume while suspended
// - reset wake: resume first, reset after 3ms
// - reset bit sets on host reset signaling
// - disconnect bit sets on disconnect done
`timescale 1ns/10ps
`include "upis_defs.vh"

module upis_core #(
  parameter DW       = 32,                       // swap path width
  parameter CNT_W    = 17,                       // interval counter width
  parameter IDLE_CYC = (`UPIS_CLK_HZ / 1000000) * `UPIS_IDLE_US,
  parameter SE0_CYC  = (`UPIS_CLK_HZ / 1000000) * `UPIS_SE0_US
) (
  input  wire          mclk,
  input  wire          nrst,
  // axi4-lite slave
  input  wire [31:0]   awaddr,
  input  wire          awvalid,
  output wire          awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output wire          wready,
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  input  wire [31:0]   araddr,
  input  wire          arvalid,
  output wire          arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  // bus line state from the serial engine
  input  wire          bus_idle,
  input  wire          bus_se0,
  input  wire          bus_resume,
  output wire          suspend_mode,
  output wire          resume_out,
  output wire          bus_reset,
  // endpoint 0 events
  input  wire          ep0_out_ready_set,
  input  wire          ep0_in_ready_clr,
  input  wire          ep0_stall_sent_set,
  input  wire          setup_end_flag_set,
  input  wire          ep0_transfer_done_clr,
  // endpoint 1..4 events, bit 0 is endpoint 1
  input  wire [3:0]    ep_iso,
  input  wire [3:0]    endpoint_in_ready_clr,
  input  wire [3:0]    ep_fifo_flush,
  input  wire [3:0]    out_stall_sent_set,
  input  wire [3:0]    in_stall_sent_set,
  input  wire [3:0]    iso_underrun,
  input  wire          disconnect_done,
  // iso in frame sync
  input  wire          iso_mode,
  input  wire          in_packet_ready,
  input  wire          sof_token,
  input  wire          in_token,
  output reg           in_send_r,
  output reg           in_zero_len_r,
  // data swap paths
  input  wire [DW-1:0] tx_data_in,
  output reg  [DW-1:0] tx_data_out_r,
  input  wire [DW-1:0] rx_data_in,
  output reg  [DW-1:0] rx_data_out_r
);

////////////////////////////////////////////////////////////////////////
// byte reversal used by both swap paths
function [DW-1:0] swap_bytes;
  input [DW-1:0] d;
  integer i;
  begin
    for (i = 0; i < DW / 8; i = i + 1) begin
      swap_bytes[i*8 +: 8] = d[DW-8-i*8 +: 8];
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// register state
reg  [7:0]       pm_r;           // power management control
reg  [11:0]      intr_r;         // interrupt status
reg              sus_en_r;       // suspend interrupt enable
reg  [CNT_W-1:0] idle_cnt_r;     // idle interval counter
reg  [CNT_W-1:0] se0_cnt_r;      // se0 persistence counter
reg              rst_seen_r;     // reset signaling present
reg              se0_d_r;        // previous se0 level
reg              ep0_in_ready_d_r;      // previous in ready level
reg              wait_sof_r;     // armed, waiting for sof
reg              go_r;           // sof seen, packet may go
reg              aw_got_r;       // write address held
reg              w_got_r;        // write data held
reg  [31:0]      aw_addr_r;      // held write address
reg  [31:0]      w_data_r;       // held write data
reg  [3:0]       w_strb_r;       // held write strobes

////////////////////////////////////////////////////////////////////////
// axi handshakes
assign awready = ~aw_got_r & ~bvalid;
assign wready  = ~w_got_r & ~bvalid;
assign arready = ~rvalid;

wire aw_hs   = awvalid & awready;  // address taken
wire w_hs    = wvalid & wready;    // data taken
wire ar_hs   = arvalid & arready;  // read taken
wire wr_go   = aw_got_r & w_got_r & ~bvalid;  // both halves held

wire wr_pm   = wr_go & (aw_addr_r == `UPIS_ADDR_PM) & w_strb_r[0];
wire wr_int  = wr_go & (aw_addr_r == `UPIS_ADDR_INTR) & w_strb_r[1];
wire wr_ic   = wr_go & (aw_addr_r == `UPIS_ADDR_IRQCTL) & w_strb_r[0];
wire rd_int  = ar_hs & (araddr == `UPIS_ADDR_INTR);

// mapped address check
wire wr_map  = (aw_addr_r == `UPIS_ADDR_PM) | (aw_addr_r == `UPIS_ADDR_INTR)
             | (aw_addr_r == `UPIS_ADDR_IRQCTL);
wire rd_map  = (araddr == `UPIS_ADDR_PM) | (araddr == `UPIS_ADDR_INTR)
             | (araddr == `UPIS_ADDR_IRQCTL);

////////////////////////////////////////////////////////////////////////
// write channel capture and response
always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    aw_got_r  <= 1'b0;
    w_got_r   <= 1'b0;
    aw_addr_r <= 32'h00000000;
    w_data_r  <= 32'h00000000;
    w_strb_r  <= 4'h0;
    bvalid    <= 1'b0;
    bresp     <= `UPIS_RESP_OKAY;
  end else begin
    if (aw_hs) begin               // latch address
      aw_got_r  <= 1'b1;
      aw_addr_r <= awaddr;
    end
    if (w_hs) begin                // latch data
      w_got_r  <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
    if (wr_go) begin               // both held: answer
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid   <= 1'b1;
      bresp    <= wr_map ? `UPIS_RESP_OKAY : `UPIS_RESP_SLVERR;
    end else if (bvalid & bready) begin
      bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// read channel, data sampled at address handshake
always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    rvalid <= 1'b0;
    rdata  <= 32'h00000000;
    rresp  <= `UPIS_RESP_OKAY;
  end else begin
    if (ar_hs) begin
      rvalid <= 1'b1;
      rresp  <= rd_map ? `UPIS_RESP_OKAY : `UPIS_RESP_SLVERR;
      case (araddr)
        `UPIS_ADDR_PM:     rdata <= {24'h000000, pm_r};
        `UPIS_ADDR_INTR:   rdata <= {20'h00000, intr_r};
        `UPIS_ADDR_IRQCTL: rdata <= {31'h00000000, sus_en_r};
        default:           rdata <= 32'h00000000;  // unmapped
      endcase
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// idle interval: one pulse per 3ms of idle bus
wire idle_tick = bus_idle & (idle_cnt_r == IDLE_CYC[CNT_W-1:0] - 1'b1);

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    idle_cnt_r <= {CNT_W{1'b0}};
  end else if (!bus_idle || idle_tick) begin
    idle_cnt_r <= {CNT_W{1'b0}};             // activity or wrap
  end else begin
    idle_cnt_r <= idle_cnt_r + 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// se0 persistence: reset signaling once held 3ms
wire se0_full = (se0_cnt_r == SE0_CYC[CNT_W-1:0] - 1'b1);

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    se0_cnt_r  <= {CNT_W{1'b0}};
    rst_seen_r <= 1'b0;
    se0_d_r    <= 1'b0;
  end else begin
    se0_d_r <= bus_se0;
    if (!bus_se0) begin                      // reset over
      se0_cnt_r  <= {CNT_W{1'b0}};
      rst_seen_r <= 1'b0;
    end else if (se0_full) begin
      rst_seen_r <= 1'b1;
    end else begin
      se0_cnt_r <= se0_cnt_r + 1'b1;
    end
  end
end

wire rst_rise = bus_se0 & se0_full & ~rst_seen_r;  // reset detected
wire se0_rise = bus_se0 & ~se0_d_r;                // se0 onset

assign bus_reset = rst_seen_r;

////////////////////////////////////////////////////////////////////////
// power management control register
wire susp    = pm_r[`UPIS_PM_SUSSTATE];
wire res_ev  = susp & (bus_resume | se0_rise);     // wake seen
wire res_clr = wr_pm & pm_r[`UPIS_PM_RESDRIVE]
             & ~w_data_r[`UPIS_PM_RESDRIVE];       // drive ended
wire res_rd  = rd_int & intr_r[`UPIS_IS_RES];      // resume serviced
wire sus_in  = idle_tick & pm_r[`UPIS_PM_SUSALLOW] & ~susp;

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    pm_r <= `UPIS_PM_RST;
  end else begin
    if (wr_pm) begin                         // software fields
      pm_r[`UPIS_PM_SUSALLOW] <= w_data_r[`UPIS_PM_SUSALLOW];
      pm_r[`UPIS_PM_RESDRIVE] <= w_data_r[`UPIS_PM_RESDRIVE];
      pm_r[`UPIS_PM_TXSWAP]   <= w_data_r[`UPIS_PM_TXSWAP];
      pm_r[`UPIS_PM_RXSWAP]   <= w_data_r[`UPIS_PM_RXSWAP];
      pm_r[`UPIS_PM_FSYNC]    <= w_data_r[`UPIS_PM_FSYNC];
    end
    // entry wins over a clear in the same cycle
    if (sus_in) begin
      pm_r[`UPIS_PM_SUSSTATE] <= 1'b1;
    end else if (res_clr || res_rd) begin
      pm_r[`UPIS_PM_SUSSTATE] <= 1'b0;
    end
    pm_r[`UPIS_PM_BUSRST] <= rst_seen_r;
    pm_r[`UPIS_PM_RSVD] <= 1'b0;             // reserved
  end
end

assign suspend_mode = susp;
// software times the drive width
assign resume_out = susp & pm_r[`UPIS_PM_RESDRIVE];

////////////////////////////////////////////////////////////////////////
// suspend interrupt enable, off after reset
always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    sus_en_r <= 1'b0;
  end else if (wr_ic) begin
    sus_en_r <= w_data_r[`UPIS_IC_SUSEN];
  end
end

////////////////////////////////////////////////////////////////////////
// endpoint event collection
wire       ep0_ev = ep0_out_ready_set | ep0_in_ready_clr
                  | ep0_stall_sent_set | setup_end_flag_set
                  | ep0_transfer_done_clr;
wire [3:0] ep_ev;

genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : g_ep
    // underrun only counts on iso endpoints
    assign ep_ev[g] = endpoint_in_ready_clr[g] | ep_fifo_flush[g]
                    | out_stall_sent_set[g] | in_stall_sent_set[g]
                    | (ep_iso[g] & iso_underrun[g]);
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// interrupt status register: set wins over read clear
wire [11:0] set_v;
assign set_v[`UPIS_IS_EP0]                = ep0_ev;
assign set_v[`UPIS_IS_EPHI:`UPIS_IS_EPLO] = ep_ev;
assign set_v[`UPIS_IS_RSVHI:`UPIS_IS_RSVLO] = 3'h0;
assign set_v[`UPIS_IS_SUS]  = idle_tick & sus_en_r;
assign set_v[`UPIS_IS_RES]  = res_ev;
assign set_v[`UPIS_IS_RST]  = rst_rise;
assign set_v[`UPIS_IS_DISC] = disconnect_done;

// read clears all but disconnect, which clears by writing one
wire [11:0] clr_v = ({12{rd_int}} & `UPIS_IS_RDCLR)
                  | ({12{wr_int & w_data_r[`UPIS_IS_DISC]}} & `UPIS_IS_W1C);

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    intr_r <= `UPIS_INTR_RST;
  end else begin
    intr_r <= set_v | (intr_r & ~clr_v);
  end
end

////////////////////////////////////////////////////////////////////////
// iso frame-synchronised in update
wire fsync    = iso_mode & pm_r[`UPIS_PM_FSYNC];
wire rdy_rise = in_packet_ready & ~ep0_in_ready_d_r;

always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    ep0_in_ready_d_r     <= 1'b0;
    wait_sof_r    <= 1'b0;
    go_r          <= 1'b0;
    in_send_r     <= 1'b0;
    in_zero_len_r <= 1'b0;
  end else begin
    ep0_in_ready_d_r     <= in_packet_ready;
    in_send_r     <= 1'b0;
    in_zero_len_r <= 1'b0;
    if (!in_packet_ready) begin              // nothing pending
      wait_sof_r <= 1'b0;
      go_r       <= 1'b0;
    end else if (rdy_rise & fsync) begin
      wait_sof_r <= 1'b1;
    end else if (wait_sof_r & sof_token) begin
      wait_sof_r <= 1'b0;
      go_r       <= 1'b1;
    end
    if (in_token) begin
      if (fsync & ~go_r) begin
        in_zero_len_r <= 1'b1;
      end else if (in_packet_ready) begin
        in_send_r <= 1'b1;
        go_r      <= 1'b0;
      end else begin
        in_zero_len_r <= 1'b0;               // no data: core naks
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// registered data swap paths
always @(posedge mclk or negedge nrst) begin
  if (!nrst) begin
    tx_data_out_r <= {DW{1'b0}};
    rx_data_out_r <= {DW{1'b0}};
  end else begin
    tx_data_out_r <= pm_r[`UPIS_PM_TXSWAP] ? swap_bytes(tx_data_in)
                                           : tx_data_in;
    rx_data_out_r <= pm_r[`UPIS_PM_RXSWAP] ? swap_bytes(rx_data_in)
                                           : rx_data_in;
  end
end

endmodule

/* File: sim/upis_host.sv */
/* host model on the cable side: line state and token pulses.
   assumes callers start just after a rising mclk edge. */
`timescale 1ns/10ps
module upis_host (
  input  wire  mclk,
  output logic bus_idle   = 1'h0,
  output logic bus_se0    = 1'h0,
  output logic bus_resume = 1'h0,
  output logic sof_token  = 1'h0,
  output logic in_token   = 1'h0
);
  ////////////////////////////////////////////////////////////
  // line state: idle j, se0 or activity
  task line(input logic idle, se0);
    bus_idle <= idle;
    bus_se0 <= se0;
  endtask
  // one-cycle resume signal from the host
  task resume;
    bus_resume <= 1'h1;
    @(posedge mclk);
    bus_resume <= 1'h0;
  endtask
  // start-of-frame token
  task sof;
    sof_token <= 1'h1;
    @(posedge mclk);
    sof_token <= 1'h0;
  endtask
  // in token, taken at the next edge
  task tok;
    in_token <= 1'h1;
    @(posedge mclk);
    in_token <= 1'h0;
  endtask
endmodule

/* File: sim/upis_core_monitor.sv */
/* checker on upis_core ports: suspend, bus reset, swap, frame sync.
   bound into every upis_core; sees its ports only. */
`timescale 1ns/10ps
module upis_core_monitor #(
  parameter DW      = 32,
  parameter SE0_CYC = 16
) (
  input wire          mclk,
  input wire          nrst,
  input wire          bus_idle,
  input wire          bus_se0,
  input wire          bus_reset,
  input wire          suspend_mode,
  input wire          resume_out,
  input wire          iso_mode,
  input wire          in_packet_ready,
  input wire          in_token,
  input wire          in_send_r,
  input wire          in_zero_len_r,
  input wire [DW-1:0] tx_data_in,
  input wire [DW-1:0] tx_data_out_r,
  input wire [DW-1:0] rx_data_in,
  input wire [DW-1:0] rx_data_out_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [31:0] se0_cnt_r; // consecutive se0 cycles
  ////////////////////////////////////////////////////////////
  // count se0 run length
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) se0_cnt_r <= 32'h0;
    else if (bus_se0) se0_cnt_r <= se0_cnt_r + 32'h1;
    else se0_cnt_r <= 32'h0;
  end
  // byte reversal of a data word
  function automatic [DW-1:0] flip(input [DW-1:0] x);
    for (int i = 0; i < DW / 8; i++) flip[8*i +: 8] = x[DW-8-8*i +: 8];
  endfunction
  ////////////////////////////////////////////////////////////
  a_resume_gate: assert property (resume_out |-> suspend_mode)
    else $error("resume driven outside suspend");
  a_susp_idle: assert property ($rose(suspend_mode) |-> $past(bus_idle))
    else $error("suspend without idle bus");
  a_rst_count: assert property ($rose(bus_reset) |-> se0_cnt_r >= SE0_CYC)
    else $error("bus reset before se0 interval");
  a_rst_drops: assert property ($fell(bus_se0) |-> ##2 !bus_reset)
    else $error("bus reset outlives se0");
  a_zero_cause: assert property (in_zero_len_r |-> $past(in_token) && $past(iso_mode))
    else $error("zero length without iso in token");
  a_send_cause: assert property (in_send_r |-> $past(in_token) && $past(in_packet_ready))
    else $error("send without ready in token");
  a_one_answer: assert property (!(in_send_r && in_zero_len_r))
    else $error("both send and zero length");
  a_tx_swap: assert property (nrst |=>
    tx_data_out_r == $past(tx_data_in) || tx_data_out_r == flip($past(tx_data_in)))
    else $error("tx data corrupted");
  a_rx_swap: assert property (nrst |=>
    rx_data_out_r == $past(rx_data_in) || rx_data_out_r == flip($past(rx_data_in)))
    else $error("rx data corrupted");
  c_suspend: cover property ($rose(suspend_mode));
  c_bus_reset: cover property ($rose(bus_reset));
  c_zero_len: cover property (in_zero_len_r);
endmodule
bind upis_core upis_core_monitor #(.DW(DW), .SE0_CYC(SE0_CYC)) u_upis_core_monitor (
  .mclk, .nrst, .bus_idle, .bus_se0, .bus_reset, .suspend_mode, .resume_out,
  .iso_mode, .in_packet_ready, .in_token, .in_send_r, .in_zero_len_r,
  .tx_data_in, .tx_data_out_r, .rx_data_in, .rx_data_out_r);

/* File: sim/tb_upis_core.sv */
/* self-checking bench for upis_core over axi4-lite.
   assumes upis_host and the checker are compiled with it. */
`timescale 1ns/10ps
`include "upis_defs.vh"
module tb_upis_core;
  localparam int CYC = 16; // shortened idle and se0 counts
  localparam logic [31:0] PM = `UPIS_ADDR_PM, IS = `UPIS_ADDR_INTR, IC = `UPIS_ADDR_IRQCTL;
  logic        mclk = 1'h0, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic        bready = 1'h1, rready = 1'h1, iso_mode = 1'h0, in_packet_ready = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d;
  logic [31:0] tx_data_in = 32'h0, rx_data_in = 32'h0;
  logic [3:0]  wstrb = 4'hf, ep_iso = 4'hf;
  logic [25:0] evt = 26'h0; // all event pulses
  logic [1:0]  resp;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, tx_data_out_r, rx_data_out_r;
  wire         awready, wready, bvalid, arready, rvalid, bus_idle, bus_se0, bus_resume;
  wire         suspend_mode, resume_out, bus_reset, sof_token, in_token, in_send_r;
  wire         in_zero_len_r;
  int          err_total = 0, checks = 0;
  // event rows: iso map, events, expected status
  logic [41:0] rows [13] = '{
    {4'hf, 26'h1, 12'h1}, {4'hf, 26'h2, 12'h1}, {4'hf, 26'h4, 12'h1},
    {4'hf, 26'h8, 12'h1}, {4'hf, 26'h10, 12'h1}, {4'hf, 26'h20, 12'h2},
    {4'hf, 26'h400, 12'h4}, {4'hf, 26'h8000, 12'h8}, {4'hf, 26'h100000, 12'h10},
    {4'hf, 26'h200000, 12'h2}, {4'h0, 26'h400000, 12'h0},
    {4'hf, 26'h2000000, 12'h800}, {4'hf, 26'h2084304, 12'h81f}};

  always #12.5 mclk = ~mclk;

  upis_core #(.IDLE_CYC(CYC), .SE0_CYC(CYC)) u_upis_core (
    .mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .bus_idle, .bus_se0, .bus_resume, .suspend_mode, .resume_out, .bus_reset,
    .ep0_out_ready_set(evt[0]), .ep0_in_ready_clr(evt[1]), .ep0_stall_sent_set(evt[2]),
    .setup_end_flag_set(evt[3]), .ep0_transfer_done_clr(evt[4]), .ep_iso,
    .endpoint_in_ready_clr(evt[8:5]), .ep_fifo_flush(evt[12:9]),
    .out_stall_sent_set(evt[16:13]), .in_stall_sent_set(evt[20:17]),
    .iso_underrun(evt[24:21]), .disconnect_done(evt[25]), .iso_mode, .in_packet_ready,
    .sof_token, .in_token, .in_send_r, .in_zero_len_r, .tx_data_in, .tx_data_out_r,
    .rx_data_in, .rx_data_out_r);
  upis_host u_upis_host (.mclk, .bus_idle, .bus_se0, .bus_resume, .sof_token, .in_token);
  ////////////////////////////////////////////////////////////
  task finish_test;
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task hang;
    err_total++;
    finish_test;
  endtask
  task cmp(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task wr(input logic [31:0] a, v);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      if (bvalid) break;
    end
    resp = bresp;
    if (n == 50) hang;
  endtask
  // read: result lands in d and resp
  task rd(input logic [31:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      arvalid <= arvalid & ~arready;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    if (n == 50) hang;
  endtask
  task rc(input logic [31:0] a, e, input string s);
    rd(a);
    cmp(s, e, d);
  endtask
  // in token and the one-cycle answer
  task tok(input logic es, ez);
    u_upis_host.tok;
    @(negedge mclk);
    cmp("send", es, in_send_r);
    cmp("zero len", ez, in_zero_len_r);
    @(posedge mclk);
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    wait_cyc(16);
    nrst <= 1'h1;
    @(posedge mclk);
    rc(PM, 32'h0, "pm reset");
    rc(IS, 32'h0, "intr reset");
    rc(PM + 32'hc, 32'h0, "unmapped rd");
    cmp("rresp", 32'h2, resp);
    wr(PM + 32'hc, 32'h1);
    cmp("bresp", 32'h2, resp);
    wr(PM, 32'hff);
    rc(PM, 32'hb5, "pm fields");
    wstrb <= 4'he;
    wr(PM, 32'h0);
    wstrb <= 4'hf;
    cmp("bresp ok", 32'h0, resp);
    rc(PM, 32'hb5, "lane0 off");
    tx_data_in <= 32'h11223344;
    rx_data_in <= 32'h55667788;
    for (int i = 0; i < 4; i++) begin
      wr(PM, i << 4);
      @(negedge mclk);
      cmp("tx", i[0] ? 32'h44332211 : 32'h11223344, tx_data_out_r);
      cmp("rx", i[1] ? 32'h88776655 : 32'h55667788, rx_data_out_r);
      @(posedge mclk);
    end
    foreach (rows[i]) begin
      ep_iso <= rows[i][41:38];
      evt <= rows[i][37:12];
      @(posedge mclk);
      evt <= 26'h0;
      @(posedge mclk);
      rc(IS, rows[i][11:0], "intr row");
      rc(IS, rows[i][11:0] & 12'h800, "intr again");
      wr(IS, 32'h800);
      rc(IS, 32'h0, "intr clr");
    end
    wr(PM, 32'h0);
    u_upis_host.line(1'h1, 1'h0);
    wait_cyc(CYC + 4);
    rc(PM, 32'h0, "no suspend");
    rc(IS, 32'h0, "sus irq off");
    wr(PM, 32'h1);
    wait_cyc(CYC + 4);
    rc(PM, 32'h3, "suspended");
    cmp("suspend_mode", 32'h1, suspend_mode);
    u_upis_host.line(1'h0, 1'h0);
    wr(PM, 32'h5);
    @(negedge mclk);
    cmp("resume_out", 32'h1, resume_out);
    @(posedge mclk);
    wait_cyc(40); // shortened software resume hold
    wr(PM, 32'h1);
    rc(PM, 32'h1, "resume end");
    cmp("suspend_mode off", 32'h0, suspend_mode);
    cmp("resume_out off", 32'h0, resume_out);
    u_upis_host.line(1'h1, 1'h0);
    wait_cyc(CYC + 4);
    u_upis_host.line(1'h0, 1'h0);
    u_upis_host.resume;
    rc(IS, 32'h200, "resume irq");
    rc(PM, 32'h1, "resume read");
    u_upis_host.line(1'h1, 1'h0);
    wait_cyc(CYC + 4);
    u_upis_host.line(1'h0, 1'h1);
    wait_cyc(3);
    rc(IS, 32'h200, "wake first");
    wait_cyc(CYC + 4);
    rc(PM, 32'h9, "reset seen");
    cmp("bus_reset", 32'h1, bus_reset);
    rc(IS, 32'h400, "reset irq");
    u_upis_host.line(1'h0, 1'h0);
    wait_cyc(4);
    rc(PM, 32'h1, "reset gone");
    cmp("bus_reset gone", 32'h0, bus_reset);
    wr(PM, 32'h0);
    wr(IC, 32'h1);
    u_upis_host.line(1'h1, 1'h0);
    wait_cyc(CYC + 2);
    rc(IS, 32'h100, "sus irq");
    wait_cyc(CYC);
    rc(IS, 32'h100, "sus irq again");
    u_upis_host.line(1'h0, 1'h0);
    iso_mode <= 1'h1;
    wr(PM, 32'h80);
    in_packet_ready <= 1'h1;
    @(posedge mclk);
    tok(1'h0, 1'h1);
    u_upis_host.sof;
    tok(1'h1, 1'h0);
    wr(PM, 32'h0);
    tok(1'h1, 1'h0);
    in_packet_ready <= 1'h0;
    @(posedge mclk);
    tok(1'h0, 1'h0);
    // mid-run reset: control bits back to their reset values
    nrst <= 1'h0;
    wait_cyc(2);
    nrst <= 1'h1;
    @(posedge mclk);
    rc(IC, 32'h0, "irqctl after reset");
    rc(PM, 32'h0, "pm after reset");
    finish_test;
  end
endmodule
